// >>> calb_defines.svh
// Offsets, widths, opcodes and reset values of the core
`ifndef CALB_DEFINES_SVH
`define CALB_DEFINES_SVH
// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define CALB_OFF_CTRL   8'h00
`define CALB_OFF_INSTR  8'h04
`define CALB_OFF_WREG   8'h08
`define CALB_OFF_STATUS 8'h0c
`define CALB_OFF_BANK   8'h10
`define CALB_OFF_PC     8'h14
`define CALB_OFF_IBASE  8'h18
`define CALB_OFF_MADDR  8'h1c
`define CALB_OFF_MDATA  8'h20
`define CALB_OFF_EXEC   8'h24
// ****************************************************************
// Widths, opcodes, addressing constants
// ****************************************************************
`define CALB_AW         12
`define CALB_PC_W       21
`define CALB_OP_ADDC    6'h08
`define CALB_OP_ANDF    6'h05
`define CALB_OP_ANDK    8'h0b
`define CALB_OP_BRC     8'he2
`define CALB_OP_BCLR    4'h9
`define CALB_IDX_LIMIT  8'h5f
`define CALB_ACC_HI     4'hf
`define CALB_PC_STEP    21'h000002
`define CALB_RST_BYTE   8'h00
`define CALB_RST_PC     21'h000000
`define CALB_RST_ADDR   12'h000
`define CALB_RST_INSTR  16'h0000
`define CALB_RST_FLAGS  5'h00
`define CALB_RST_BANK   4'h0
`endif

// >>> calb_pkg.sv
// Types shared by the core: phase states and status flags
package calb_pkg;
    // Instruction phases plus the idle slot and the dead cycle
    typedef enum logic [3:0] {
        ST_IDLE, ST_Q1, ST_Q2, ST_Q3, ST_Q4,
        ST_N1, ST_N2, ST_N3, ST_N4
    } calb_state_t;
    // Status flags, packed in status register order
    typedef struct packed {
        logic n;
        logic ovfl;
        logic z;
        logic dcar;
        logic c;
    } calb_flags_t;
endpackage

// >>> calb_core.sv
// Execution core for add/and/branch/bit-clear ops with APB access
//
// Functional notes
// - add_accum_carry_to_file sums W, the file byte and carry.
// - Destination bit 0 writes W, destination bit 1 writes the file.
// - add_accum_carry_to_file updates all five status flags.
// - Access bit 0 uses the access bank, 1 uses bank_select_reg.
// - Extended mode with access 0 and f <= 5Fh adds the index base.
// - and_literal_into_accum ANDs W with the literal into W.
// - and_accum_with_file ANDs W with the file byte into the dest.
// - Both AND ops change only the N and Z flags.
// - branch_on_carry_set branches only when carry is one.
// - A taken branch loads PC + 2 + 2n into program_counter.
// - A branch takes one cycle, or two when taken, the second idle.
`timescale 1ns/10ps
`default_nettype none
`include "calb_defines.svh"
module calb_core
    import calb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int AW = `CALB_AW;
    localparam int PW = `CALB_PC_W;

    // ************************************************************
    // Effective address decode
    // ************************************************************
    function automatic logic [AW-1:0] eff_addr(
        input logic [7:0]    f,
        input logic          a,
        input logic          ext,
        input logic [AW-1:0] base,
        input logic [3:0]    bank
    );
        if (a) begin
            return {bank, f};
        end else if (ext && f <= `CALB_IDX_LIMIT) begin
            return base + {4'h0, f};
        end else if (f <= `CALB_IDX_LIMIT) begin
            return {`CALB_RST_BANK, f};
        end else begin
            return {`CALB_ACC_HI, f};
        end
    endfunction

    logic [15:0]   instr_q;
    logic [7:0]    w_q;
    logic [7:0]    opnd_q;
    logic [7:0]    res_q;
    calb_flags_t   flg_q;
    calb_flags_t   fnew_q;
    calb_flags_t   fcalc;
    logic [3:0]    bank_q;
    logic [PW-1:0] pc_q;
    logic          ext_q;
    logic          unsup_q;
    logic [AW-1:0] ibase_q;
    logic [AW-1:0] maddr_q;
    logic [AW-1:0] ea_q;
    calb_state_t   st_q;
    logic [7:0]    dmem [0:(2**AW)-1];

    // ************************************************************
    // Instruction decode
    // ************************************************************
    wire is_add  = instr_q[15:10] == `CALB_OP_ADDC;
    wire is_andw = instr_q[15:10] == `CALB_OP_ANDF;
    wire is_andl = instr_q[15:8] == `CALB_OP_ANDK;
    wire is_bc   = instr_q[15:8] == `CALB_OP_BRC;
    wire is_bcf  = instr_q[15:12] == `CALB_OP_BCLR;
    wire dbit    = instr_q[9];
    wire abit    = instr_q[8];
    wire uses_f  = is_add | is_andw | is_bcf;
    wire known   = uses_f | is_andl | is_bc;
    wire to_file = ((is_add | is_andw) & dbit) | is_bcf;
    wire to_w    = ((is_add | is_andw) & ~dbit) | is_andl;
    wire take    = is_bc & flg_q.c;
    wire busy    = st_q != ST_IDLE;

    // ************************************************************
    // Arithmetic and logic
    // ************************************************************
    wire [8:0] sum9 = {1'b0, w_q} + {1'b0, opnd_q} + {8'h00, flg_q.c};
    wire [4:0] nib  = {1'b0, w_q[3:0]} + {1'b0, opnd_q[3:0]}
                      + {4'h0, flg_q.c};
    wire [7:0] and_r = w_q & opnd_q;
    wire [7:0] mask  = 8'h01 << instr_q[11:9];
    wire [7:0] bcf_r = opnd_q & ~mask;
    wire [7:0] alu_r = is_add ? sum9[7:0] : (is_bcf ? bcf_r : and_r);
    wire       ovf   = (w_q[7] == opnd_q[7]) && (sum9[7] != w_q[7]);
    wire       zero  = alu_r == `CALB_RST_BYTE;

    // Flags kept unless the op owns them
    always_comb begin
        fcalc = flg_q;
        if (is_add) begin
            fcalc = '{n: alu_r[7], ovfl: ovf, z: zero,
                      dcar: nib[4], c: sum9[8]};
        end else if (is_andw | is_andl) begin
            fcalc.n = alu_r[7];
            fcalc.z = zero;
        end
    end

    // Relative target, offset doubled and sign extended
    wire [PW-1:0] pc_inc = pc_q + `CALB_PC_STEP;
    wire [PW-1:0] off2   = {{(PW-9){instr_q[7]}}, instr_q[7:0], 1'b0};
    wire [PW-1:0] pc_tgt = pc_inc + off2;

    // ************************************************************
    // APB slave decode
    // ************************************************************
    // One wait state so every answer comes from a flop
    wire acc     = psel & penable & ~pready;
    wire s_ctrl  = paddr == `CALB_OFF_CTRL;
    wire s_instr = paddr == `CALB_OFF_INSTR;
    wire s_w     = paddr == `CALB_OFF_WREG;
    wire s_stat  = paddr == `CALB_OFF_STATUS;
    wire s_bank  = paddr == `CALB_OFF_BANK;
    wire s_pc    = paddr == `CALB_OFF_PC;
    wire s_ibase = paddr == `CALB_OFF_IBASE;
    wire s_maddr = paddr == `CALB_OFF_MADDR;
    wire s_mdata = paddr == `CALB_OFF_MDATA;
    wire s_exec  = paddr == `CALB_OFF_EXEC;
    wire mapped  = |{s_ctrl, s_instr, s_w, s_stat, s_bank, s_pc,
                     s_ibase, s_maddr, s_mdata, s_exec};
    // Writes during execution are refused to keep one writer per reg
    wire wr_ok   = acc & pwrite & mapped & ~busy;
    wire err_d   = acc & (~mapped | (pwrite & busy));
    wire [31:0] rd_mux =
        s_ctrl  ? {31'h0, ext_q} :
        s_instr ? {16'h0, instr_q} :
        s_w     ? {24'h0, w_q} :
        s_stat  ? {27'h0, flg_q} :
        s_bank  ? {28'h0, bank_q} :
        s_pc    ? {11'h0, pc_q} :
        s_ibase ? {20'h0, ibase_q} :
        s_maddr ? {20'h0, maddr_q} :
        s_mdata ? {24'h0, dmem[maddr_q]} :
        s_exec  ? {30'h0, unsup_q, busy} : 32'h0;

    // Bus answer flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= acc;
            pslverr <= err_d;
            prdata  <= (acc & ~pwrite & mapped) ? rd_mux : 32'h0;
        end
    end

    // ************************************************************
    // Phase sequencer
    // ************************************************************
    // Writing the instruction register launches one instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
        end else begin
            unique case (st_q)
                ST_IDLE: st_q <= (wr_ok & s_instr) ? ST_Q1 : ST_IDLE;
                ST_Q1:   st_q <= ST_Q2;
                ST_Q2:   st_q <= ST_Q3;
                ST_Q3:   st_q <= ST_Q4;
                ST_Q4:   st_q <= take ? ST_N1 : ST_IDLE;
                ST_N1:   st_q <= ST_N2;
                ST_N2:   st_q <= ST_N3;
                ST_N3:   st_q <= ST_N4;
                ST_N4:   st_q <= ST_IDLE;
            endcase
        end
    end

    // Decode, operand read and process phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ea_q    <= `CALB_RST_ADDR;
            opnd_q  <= `CALB_RST_BYTE;
            res_q   <= `CALB_RST_BYTE;
            fnew_q  <= `CALB_RST_FLAGS;
            unsup_q <= 1'b0;
        end else begin
            if (st_q == ST_Q1) begin
                ea_q    <= eff_addr(instr_q[7:0], abit, ext_q,
                                    ibase_q, bank_q);
                unsup_q <= ~known;
            end
            if (st_q == ST_Q2) begin
                opnd_q <= uses_f ? dmem[ea_q] : instr_q[7:0];
            end
            if (st_q == ST_Q3) begin
                res_q  <= alu_r;
                fnew_q <= fcalc;
            end
        end
    end

    // ************************************************************
    // Architectural state, written in Q4 or by software when idle
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= `CALB_RST_INSTR;
            w_q     <= `CALB_RST_BYTE;
            flg_q   <= `CALB_RST_FLAGS;
            bank_q  <= `CALB_RST_BANK;
            pc_q    <= `CALB_RST_PC;
            ext_q   <= 1'b0;
            ibase_q <= `CALB_RST_ADDR;
            maddr_q <= `CALB_RST_ADDR;
        end else if (st_q == ST_Q4) begin
            if (to_w) begin
                w_q <= res_q;
            end
            if (is_add | is_andw | is_andl) begin
                flg_q <= fnew_q;
            end
            pc_q <= take ? pc_tgt : pc_inc;
        end else if (wr_ok) begin
            if (s_instr) instr_q <= pwdata[15:0];
            if (s_w)     w_q     <= pwdata[7:0];
            if (s_stat)  flg_q   <= pwdata[4:0];
            if (s_bank)  bank_q  <= pwdata[3:0];
            if (s_pc)    pc_q    <= pwdata[PW-1:0];
            if (s_ctrl)  ext_q   <= pwdata[0];
            if (s_ibase) ibase_q <= pwdata[AW-1:0];
            if (s_maddr) maddr_q <= pwdata[AW-1:0];
        end
    end

    // Data memory; file write-back happens only in Q4
    always_ff @(posedge pclk) begin
        if (st_q == ST_Q4 && to_file) begin
            dmem[ea_q] <= res_q;
        end else if (wr_ok && s_mdata) begin
            dmem[maddr_q] <= pwdata[7:0];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_q3(op);
        st_q == ST_Q3 && op;
    endsequence
    sequence s_dead;
        st_q == ST_N1 ##1 st_q == ST_N2 ##1 st_q == ST_N3
        ##1 st_q == ST_N4 ##1 st_q == ST_IDLE;
    endsequence

    a_adc_sum_w: assert property (
        s_q3(is_add && !dbit) |-> ##2 w_q == $past(sum9[7:0], 2))
        else $error("add with carry result wrong in W");
    a_adc_flags: assert property (
        s_q3(is_add) |-> ##2 (flg_q.c == $past(sum9[8], 2)
            && flg_q.dcar == $past(nib[4], 2)
            && flg_q.n == $past(sum9[7], 2)
            && flg_q.ovfl == $past(ovf, 2)
            && flg_q.z == ($past(sum9[7:0], 2) == 8'h00)))
        else $error("add with carry flags wrong");
    a_dest_file: assert property (
        (st_q == ST_Q4 && to_file) |=>
            dmem[$past(ea_q)] == $past(res_q) && w_q == $past(w_q))
        else $error("file destination not written");
    a_access_bank: assert property (
        (st_q == ST_Q1 && abit) |=>
            ea_q == {$past(bank_q), $past(instr_q[7:0])})
        else $error("banked address wrong");
    a_index_mode: assert property (
        (st_q == ST_Q1 && !abit && ext_q
            && instr_q[7:0] <= `CALB_IDX_LIMIT) |=>
            ea_q == $past(ibase_q) + {4'h0, $past(instr_q[7:0])})
        else $error("indexed offset address wrong");
    a_and_literal: assert property (
        s_q3(is_andl) |-> ##2
            w_q == ($past(w_q, 2) & $past(instr_q[7:0], 2)))
        else $error("AND literal result wrong");
    a_and_file: assert property (
        s_q3(is_andw && !dbit) |-> ##2
            w_q == ($past(w_q, 2) & $past(opnd_q, 2)))
        else $error("AND file result wrong");
    a_and_flags: assert property (
        s_q3(is_andw || is_andl) |-> ##2 (flg_q.c == $past(flg_q.c, 2)
            && flg_q.ovfl == $past(flg_q.ovfl, 2)
            && flg_q.dcar == $past(flg_q.dcar, 2)
            && flg_q.z == ($past(alu_r, 2) == 8'h00)
            && flg_q.n == $past(alu_r[7], 2)))
        else $error("AND touched wrong flags");
    a_branch_skip: assert property (
        (st_q == ST_Q4 && is_bc && !flg_q.c) |=>
            st_q == ST_IDLE && pc_q == $past(pc_q) + `CALB_PC_STEP)
        else $error("untaken branch misbehaved");
    a_branch_tgt: assert property (
        (st_q == ST_Q4 && is_bc && flg_q.c) |=>
            pc_q == $past(pc_q) + `CALB_PC_STEP + $past(off2))
        else $error("branch target wrong");
    a_branch_dead: assert property (
        (st_q == ST_Q4 && take) |=> s_dead)
        else $error("taken branch dead cycle wrong");
    a_bit_clear: assert property (
        (st_q == ST_Q4 && is_bcf) |=>
            dmem[$past(ea_q)] == ($past(opnd_q) & ~$past(mask))
            && flg_q == $past(flg_q))
        else $error("bit clear wrong");
    a_phase_order: assert property (
        st_q == ST_Q1 |=> st_q == ST_Q2 ##1 st_q == ST_Q3
            ##1 st_q == ST_Q4)
        else $error("phase order broken");
endmodule
`default_nettype wire

// >>> test_cpu_arith_logic_branch_ops.sv
// Self-checking testbench for the add, and, branch and bit-clear core
`timescale 1ns/10ps
`default_nettype none
`include "calb_defines.svh"
module test_cpu_arith_logic_branch_ops
    import calb_pkg::*;
;
    // One table row: instruction, start state, expected end state
    typedef struct {
        logic [15:0] ins;
        logic [7:0]  w, m, st, ew, em, est;
    } calb_row_t;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] rd;
    logic        er;
    int          miscompares;
    int          tests_run;
    int          k;

    // ****************************************************************
    // Ordinary cases; file operands all on byte 20h in the access bank
    // ****************************************************************
    calb_row_t rows [9] = '{
        '{16'h2220, 8'h02, 8'h4d, 8'h01, 8'h02, 8'h50, 8'h02},
        '{16'h2020, 8'h7f, 8'h00, 8'h01, 8'h80, 8'h00, 8'h1a},
        '{16'h2020, 8'hff, 8'h01, 8'h00, 8'h00, 8'h01, 8'h07},
        '{16'h0b5f, 8'ha3, 8'h11, 8'h0b, 8'h03, 8'h11, 8'h0b},
        '{16'h0b7f, 8'h80, 8'h11, 8'h10, 8'h00, 8'h11, 8'h04},
        '{16'h1420, 8'h17, 8'hc2, 8'h03, 8'h02, 8'hc2, 8'h03},
        '{16'h1620, 8'hf0, 8'h9c, 8'h00, 8'hf0, 8'h90, 8'h10},
        '{16'h9e20, 8'h55, 8'hc7, 8'h1f, 8'h55, 8'h47, 8'h1f},
        '{16'h9020, 8'h55, 8'h01, 8'h00, 8'h55, 8'h00, 8'h00}
    };

    calb_core calb_core_i (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task wrap_up;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // APB transfer; held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            miscompares++;
            wrap_up();
        end
    endtask

    task put(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task get(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task mem(input logic [11:0] a, input logic [7:0] d);
        put(`CALB_OFF_MADDR, 32'(a));
        put(`CALB_OFF_MDATA, 32'(d));
    endtask

    // Poll the busy bit with a bounded count
    task idle;
        int i;
        for (i = 0; i < 20; i++) begin
            get(`CALB_OFF_EXEC);
            if (rd[0] === 1'b0) break;
        end
        if (i == 20) begin
            miscompares++;
            wrap_up();
        end
    endtask

    task run(input logic [15:0] ins);
        put(`CALB_OFF_INSTR, 32'(ins));
        idle();
    endtask

    // Branch from 100h with a given status; flags must survive
    task br(input logic [7:0] st, input logic [15:0] ins,
            input logic [31:0] pc);
        put(`CALB_OFF_PC, 32'h100);
        put(`CALB_OFF_STATUS, 32'(st));
        run(ins);
        get(`CALB_OFF_PC);
        chk(rd, pc);
        get(`CALB_OFF_STATUS);
        chk(rd, 32'(st));
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        miscompares = 0;
        tests_run = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        get(`CALB_OFF_WREG);
        chk(rd, 32'h0);
        get(`CALB_OFF_STATUS);
        chk(rd, 32'h0);
        get(`CALB_OFF_PC);
        chk(rd, 32'h0);
        // Table of byte, literal and bit operations
        for (k = 0; k < 9; k++) begin
            put(`CALB_OFF_WREG, 32'(rows[k].w));
            put(`CALB_OFF_STATUS, 32'(rows[k].st));
            mem(12'h020, rows[k].m);
            run(rows[k].ins);
            get(`CALB_OFF_WREG);
            chk(rd, 32'(rows[k].ew));
            get(`CALB_OFF_MDATA);
            chk(rd, 32'(rows[k].em));
            get(`CALB_OFF_STATUS);
            chk(rd, 32'(rows[k].est));
        end
        // Banked access through the bank select register
        put(`CALB_OFF_BANK, 32'h3);
        put(`CALB_OFF_WREG, 32'h0f);
        mem(12'h340, 8'h3c);
        run(16'h1740);
        get(`CALB_OFF_MDATA);
        chk(rd, 32'h0c);
        // Indexed offset at the 5Fh boundary and just above it
        put(`CALB_OFF_CTRL, 32'h1);
        put(`CALB_OFF_IBASE, 32'h100);
        mem(12'h15f, 8'hff);
        run(16'h925f);
        get(`CALB_OFF_MDATA);
        chk(rd, 32'hfd);
        mem(12'hf60, 8'h01);
        run(16'h9060);
        get(`CALB_OFF_MDATA);
        chk(rd, 32'h00);
        put(`CALB_OFF_CTRL, 32'h0);
        // Branches: taken forward, taken at -128, two not taken
        br(8'h01, 16'he205, 32'h10c);
        br(8'h01, 16'he280, 32'h002);
        br(8'h00, 16'he205, 32'h102);
        br(8'h1e, 16'he205, 32'h102);
        // Unknown opcode only steps the counter and flags itself
        run(16'hffff);
        chk(rd, 32'h2);
        get(`CALB_OFF_PC);
        chk(rd, 32'h104);
        // Unmapped address is refused
        get(8'h28);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        // A write while busy is refused and leaves W alone
        put(`CALB_OFF_WREG, 32'h33);
        put(`CALB_OFF_INSTR, 32'h0b00);
        put(`CALB_OFF_WREG, 32'h77);
        chk(32'(er), 32'h1);
        idle();
        get(`CALB_OFF_WREG);
        chk(rd, 32'h0);
        // Reset while idle returns the registers to zero
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        get(`CALB_OFF_PC);
        chk(rd, 32'h0);
        get(`CALB_OFF_EXEC);
        chk(rd, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
